// ==== mvd_defs.svh ====
`ifndef MVD_DEFS_SVH
`define MVD_DEFS_SVH

`define MVD_F_TOP       15:12
`define MVD_F_GRP       15:14
`define MVD_F_SIZE      13:12
`define MVD_F_DREG      11:9
`define MVD_F_DMODE     8:6
`define MVD_F_SMODE     5:3
`define MVD_F_SREG      2:0
`define MVD_F_SXSUB     8:7
`define MVD_F_SXSZ      6
`define MVD_F_QDATA     11:9

`define MVD_GRP_MOVE    2'h0
`define MVD_SZ_NONE     2'h0
`define MVD_SZ_BYTE     2'h1
`define MVD_SZ_WORD     2'h3
`define MVD_SZ_LONG     2'h2
`define MVD_TOP_QUICK   4'ha
`define MVD_SUB_QUICK   3'h5
`define MVD_TOP_SEXT    4'h7
`define MVD_SUB_SEXT    2'h2
`define MVD_SXSZ_WORD   1'h1

`define MVD_MODE_DREG   3'h0
`define MVD_MODE_AREG   3'h1
`define MVD_MODE_IND    3'h2
`define MVD_MODE_POST   3'h3
`define MVD_MODE_PRE    3'h4
`define MVD_MODE_D16    3'h5
`define MVD_MODE_IDX    3'h6
`define MVD_MODE_EXT    3'h7
`define MVD_EXT_ABSW    3'h0
`define MVD_EXT_ABSL    3'h1
`define MVD_EXT_PCD16   3'h2
`define MVD_EXT_PCIDX   3'h3
`define MVD_EXT_IMM     3'h4

`define MVD_Q_MINUS1    3'h0
`define MVD_Q_M1_VAL    32'hffffffff
`define MVD_BYTE_MSB    7
`define MVD_WORD_MSB    15
`define MVD_LONG_MSB    31

`endif

// ==== mvd_pkg.sv ====
package mvd_pkg;
`include "mvd_defs.svh"

	typedef enum logic [1:0] {
		MVD_SZ_BYTE = `MVD_SZ_BYTE,
		MVD_SZ_WORD = `MVD_SZ_WORD,
		MVD_SZ_LONG = `MVD_SZ_LONG,
		MVD_SZ_NONE = `MVD_SZ_NONE
	} mvd_size_t;

	typedef enum logic [3:0] {
		MVD_OP_NONE  = 4'h0,
		MVD_OP_MOVE  = 4'h1,
		MVD_OP_AREG  = 4'h2,
		MVD_OP_QUICK = 4'h4,
		MVD_OP_SEXT  = 4'h8
	} mvd_op_t;

	typedef enum logic [2:0] {
		MVD_X_ZBYTE = 3'h0,
		MVD_X_ZWORD = 3'h1,
		MVD_X_SBYTE = 3'h2,
		MVD_X_SWORD = 3'h3,
		MVD_X_LONG  = 3'h4,
		MVD_X_QUICK = 3'h5
	} mvd_ext_t;

endpackage

// ==== mvd_ea_check.sv ====
`timescale 1ns/10ps
`include "mvd_defs.svh"

module mvd_ea_check (
	input  wire logic [2:0] mode_i,
	input  wire logic [2:0] reg_i,
	output logic            src_ok_o,
	output logic            dst_ok_o,
	output logic            is_areg_o,
	output logic            src_ext_o,
	output logic            dst_far_o,
	output logic            is_imm_o
);

	logic ext_mode;

	assign ext_mode  = (mode_i == `MVD_MODE_EXT);
	// Every register mode is a source; extension subcodes stop at immediate.
	assign src_ok_o  = !ext_mode || (reg_i <= `MVD_EXT_IMM);
	// Data alterable: no address register, only the two absolute subcodes.
	assign dst_ok_o  = (mode_i != `MVD_MODE_AREG) &&
		(!ext_mode || reg_i == `MVD_EXT_ABSW || reg_i == `MVD_EXT_ABSL);
	assign is_areg_o = (mode_i == `MVD_MODE_AREG);
	assign src_ext_o = (mode_i == `MVD_MODE_D16) || (mode_i == `MVD_MODE_IDX) || ext_mode;
	assign dst_far_o = (mode_i == `MVD_MODE_IDX) || ext_mode;
	assign is_imm_o  = ext_mode && (reg_i == `MVD_EXT_IMM);

endmodule

// ==== mvd_extend.sv ====
`timescale 1ns/10ps
`include "mvd_defs.svh"

module mvd_extend (
	input  wire logic [31:0]            data_i,
	input  wire logic [2:0]             qdata_i,
	input  wire mvd_pkg::mvd_ext_t      kind_i,
	output logic      [31:0]            data_o
);

	always_comb begin
		case (kind_i)
			mvd_pkg::MVD_X_ZBYTE: data_o = {24'h000000, data_i[`MVD_BYTE_MSB:0]};
			mvd_pkg::MVD_X_ZWORD: data_o = {16'h0000, data_i[`MVD_WORD_MSB:0]};
			mvd_pkg::MVD_X_SBYTE: data_o = {{24{data_i[`MVD_BYTE_MSB]}}, data_i[`MVD_BYTE_MSB:0]};
			mvd_pkg::MVD_X_SWORD: data_o = {{16{data_i[`MVD_WORD_MSB]}}, data_i[`MVD_WORD_MSB:0]};
			mvd_pkg::MVD_X_QUICK: begin
				// Code zero stands for minus one, so zero itself cannot be encoded.
				if (qdata_i == `MVD_Q_MINUS1) begin
					data_o = `MVD_Q_M1_VAL;
				end else begin
					data_o = {29'h00000000, qdata_i};
				end
			end
			default: data_o = data_i;
		endcase
	end

endmodule

// ==== mvd_top.sv ====
`timescale 1ns/10ps
`include "mvd_defs.svh"

// Function
// - Register-class sources allow every legal destination.
// - Extended sources forbid indexed and absolute destinations.
// - Immediate to displacement destination: byte, word only.
// - Move size: 01 byte, 11 word, 10 long.
// - Address move size: 11 word, 10 long.
// - Address move destination is address register only.
// - Address move accepts every source mode.
// - Address move leaves condition codes unchanged.
// - Quick move: top 1010, bits 8-6 101.
// - Quick data zero means minus one.
// - Quick move is long, writes 32 bits.
// - Quick move rejects immediate and PC-relative destinations.
// - Byte sign move replicates bit 7 upward.
// - Word sign move replicates bit 15 upward.
// - Sign move: byte or word, data register destination.
// - Sign move: top 0111, bits 8-7 10.

module mvd_top (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        valid_i,
	input  wire logic [15:0] instr_i,
	input  wire logic [31:0] src_data_i,
	output logic             done_o,
	output logic             illegal_o,
	output logic             unhandled_o,
	output logic             wr_dreg_o,
	output logic             wr_areg_o,
	output logic             wr_mem_o,
	output logic [2:0]       dst_mode_o,
	output logic [2:0]       dst_reg_o,
	output logic [1:0]       wr_size_o,
	output logic [31:0]      wr_data_o,
	output logic             ccr_upd_o,
	output logic             ccr_n_o,
	output logic             ccr_z_o
);

	logic [1:0]          size_fld;
	logic [2:0]          dreg_fld;
	logic [2:0]          dmode_fld;
	logic [2:0]          smode_fld;
	logic [2:0]          sreg_fld;

	logic                s_src_ok;
	logic                s_dst_ok;
	logic                s_areg;
	logic                s_ext;
	logic                s_imm;
	logic                d_dst_ok;
	logic                d_areg;
	logic                d_far;

	logic                hit_move;
	logic                hit_quick;
	logic                hit_sext;
	logic                ok_move;
	logic                ok_areg;
	logic                ok_quick;
	logic                ok_sext;

	mvd_pkg::mvd_op_t    op;
	mvd_pkg::mvd_ext_t   ext_kind;
	mvd_pkg::mvd_size_t  op_size;
	logic                legal;
	logic [2:0]          tgt_mode;
	logic [2:0]          tgt_reg;
	logic [31:0]         ext_data;
	logic                res_n;
	logic                res_z;

	logic                done_r;
	logic                illegal_r;
	logic                unhandled_r;
	logic                wr_dreg_r;
	logic                wr_areg_r;
	logic                wr_mem_r;
	logic [2:0]          dst_mode_r;
	logic [2:0]          dst_reg_r;
	logic [1:0]          wr_size_r;
	logic [31:0]         wr_data_r;
	logic                ccr_upd_r;
	logic                ccr_n_r;
	logic                ccr_z_r;

	assign size_fld  = instr_i[`MVD_F_SIZE];
	assign dreg_fld  = instr_i[`MVD_F_DREG];
	assign dmode_fld = instr_i[`MVD_F_DMODE];
	assign smode_fld = instr_i[`MVD_F_SMODE];
	assign sreg_fld  = instr_i[`MVD_F_SREG];

	// Low effective-address field: source for moves, destination for quick move.
	mvd_ea_check u_src_ea (
		.mode_i    (smode_fld),
		.reg_i     (sreg_fld),
		.src_ok_o  (s_src_ok),
		.dst_ok_o  (s_dst_ok),
		.is_areg_o (s_areg),
		.src_ext_o (s_ext),
		.dst_far_o (),
		.is_imm_o  (s_imm)
	);

	mvd_ea_check u_dst_ea (
		.mode_i    (dmode_fld),
		.reg_i     (dreg_fld),
		.src_ok_o  (),
		.dst_ok_o  (d_dst_ok),
		.is_areg_o (d_areg),
		.src_ext_o (),
		.dst_far_o (d_far),
		.is_imm_o  ()
	);

	mvd_extend u_ext (
		.data_i  (src_data_i),
		.qdata_i (instr_i[`MVD_F_QDATA]),
		.kind_i  (ext_kind),
		.data_o  (ext_data)
	);

	// Class hits; the move group with size zero belongs to another instruction.
	assign hit_move  = (instr_i[`MVD_F_GRP] == `MVD_GRP_MOVE) && (size_fld != `MVD_SZ_NONE);
	assign hit_quick = (instr_i[`MVD_F_TOP] == `MVD_TOP_QUICK) && (dmode_fld == `MVD_SUB_QUICK);
	assign hit_sext  = (instr_i[`MVD_F_TOP] == `MVD_TOP_SEXT) &&
		(instr_i[`MVD_F_SXSUB] == `MVD_SUB_SEXT);

	// Plain move: register-class sources reach every data alterable destination.
	assign ok_move  = s_src_ok && d_dst_ok &&
		!(s_ext && d_far) &&
		!(s_imm && dmode_fld == `MVD_MODE_D16 && size_fld == `MVD_SZ_LONG);
	// Address move: no byte form exists; every source mode is accepted.
	assign ok_areg  = s_src_ok && (size_fld != `MVD_SZ_BYTE);
	// The low field is the destination here, so address registers count as well.
	assign ok_quick = s_dst_ok || s_areg;
	assign ok_sext  = s_src_ok;

	// Opcode class and legality of the word offered this cycle.
	always_comb begin
		op    = mvd_pkg::MVD_OP_NONE;
		legal = 1'b0;
		if (hit_move && d_areg) begin
			op    = mvd_pkg::MVD_OP_AREG;
			legal = ok_areg;
		end else if (hit_move) begin
			op    = mvd_pkg::MVD_OP_MOVE;
			legal = ok_move;
		end else if (hit_quick) begin
			op    = mvd_pkg::MVD_OP_QUICK;
			legal = ok_quick;
		end else if (hit_sext) begin
			op    = mvd_pkg::MVD_OP_SEXT;
			legal = ok_sext;
		end
	end

	// Operation size as the move encodes it; the other classes fix their own.
	always_comb begin
		case (op)
			mvd_pkg::MVD_OP_MOVE,
			mvd_pkg::MVD_OP_AREG: op_size = mvd_pkg::mvd_size_t'(size_fld);
			mvd_pkg::MVD_OP_QUICK: op_size = mvd_pkg::MVD_SZ_LONG;
			mvd_pkg::MVD_OP_SEXT: begin
				if (instr_i[`MVD_F_SXSZ] == `MVD_SXSZ_WORD) begin
					op_size = mvd_pkg::MVD_SZ_WORD;
				end else begin
					op_size = mvd_pkg::MVD_SZ_BYTE;
				end
			end
			default: op_size = mvd_pkg::MVD_SZ_NONE;
		endcase
	end

	// How the operand is widened to 32 bits before it is written.
	always_comb begin
		case (op)
			mvd_pkg::MVD_OP_AREG: begin
				if (size_fld == `MVD_SZ_WORD) begin
					ext_kind = mvd_pkg::MVD_X_SWORD;
				end else begin
					ext_kind = mvd_pkg::MVD_X_LONG;
				end
			end
			mvd_pkg::MVD_OP_MOVE: begin
				case (size_fld)
					`MVD_SZ_BYTE: ext_kind = mvd_pkg::MVD_X_ZBYTE;
					`MVD_SZ_WORD: ext_kind = mvd_pkg::MVD_X_ZWORD;
					default:      ext_kind = mvd_pkg::MVD_X_LONG;
				endcase
			end
			mvd_pkg::MVD_OP_QUICK: ext_kind = mvd_pkg::MVD_X_QUICK;
			mvd_pkg::MVD_OP_SEXT: begin
				if (instr_i[`MVD_F_SXSZ] == `MVD_SXSZ_WORD) begin
					ext_kind = mvd_pkg::MVD_X_SWORD;
				end else begin
					ext_kind = mvd_pkg::MVD_X_SBYTE;
				end
			end
			default: ext_kind = mvd_pkg::MVD_X_LONG;
		endcase
	end

	// The quick move names its target in the low field, the others in the high one.
	always_comb begin
		case (op)
			mvd_pkg::MVD_OP_QUICK: begin
				tgt_mode = smode_fld;
				tgt_reg  = sreg_fld;
			end
			mvd_pkg::MVD_OP_SEXT: begin
				tgt_mode = `MVD_MODE_DREG;
				tgt_reg  = dreg_fld;
			end
			default: begin
				tgt_mode = dmode_fld;
				tgt_reg  = dreg_fld;
			end
		endcase
	end

	// Flags follow the moved value at its own width; extended results are 32 bits.
	always_comb begin
		res_z = (ext_data == 32'h00000000);
		if (op == mvd_pkg::MVD_OP_MOVE && op_size == mvd_pkg::MVD_SZ_BYTE) begin
			res_n = ext_data[`MVD_BYTE_MSB];
		end else if (op == mvd_pkg::MVD_OP_MOVE && op_size == mvd_pkg::MVD_SZ_WORD) begin
			res_n = ext_data[`MVD_WORD_MSB];
		end else begin
			res_n = ext_data[`MVD_LONG_MSB];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_r      <= 1'b0;
			illegal_r   <= 1'b0;
			unhandled_r <= 1'b0;
		end else begin
			done_r      <= valid_i && op != mvd_pkg::MVD_OP_NONE && legal;
			// An illegal word never reaches the write strobes below.
			illegal_r   <= valid_i && op != mvd_pkg::MVD_OP_NONE && !legal;
			unhandled_r <= valid_i && op == mvd_pkg::MVD_OP_NONE;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_dreg_r <= 1'b0;
			wr_areg_r <= 1'b0;
			wr_mem_r  <= 1'b0;
		end else begin
			wr_dreg_r <= valid_i && legal && tgt_mode == `MVD_MODE_DREG && op != mvd_pkg::MVD_OP_NONE;
			wr_areg_r <= valid_i && legal && tgt_mode == `MVD_MODE_AREG && op != mvd_pkg::MVD_OP_NONE;
			wr_mem_r  <= valid_i && legal && tgt_mode != `MVD_MODE_DREG && tgt_mode != `MVD_MODE_AREG &&
				op != mvd_pkg::MVD_OP_NONE;
		end
	end

	// Data and target hold until the next legal instruction replaces them.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dst_mode_r <= 3'h0;
			dst_reg_r  <= 3'h0;
			wr_size_r  <= `MVD_SZ_NONE;
			wr_data_r  <= 32'h00000000;
		end else if (valid_i && legal && op != mvd_pkg::MVD_OP_NONE) begin
			dst_mode_r <= tgt_mode;
			dst_reg_r  <= tgt_reg;
			// Extended and address results always land as a full register.
			wr_size_r  <= (op == mvd_pkg::MVD_OP_MOVE) ? op_size : `MVD_SZ_LONG;
			wr_data_r  <= ext_data;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ccr_upd_r <= 1'b0;
			ccr_n_r   <= 1'b0;
			ccr_z_r   <= 1'b0;
		end else begin
			ccr_upd_r <= valid_i && legal && op != mvd_pkg::MVD_OP_NONE &&
				op != mvd_pkg::MVD_OP_AREG;
			if (valid_i && legal && op != mvd_pkg::MVD_OP_NONE && op != mvd_pkg::MVD_OP_AREG) begin
				ccr_n_r <= res_n;
				ccr_z_r <= res_z;
			end
		end
	end

	assign done_o      = done_r;
	assign illegal_o   = illegal_r;
	assign unhandled_o = unhandled_r;
	assign wr_dreg_o   = wr_dreg_r;
	assign wr_areg_o   = wr_areg_r;
	assign wr_mem_o    = wr_mem_r;
	assign dst_mode_o  = dst_mode_r;
	assign dst_reg_o   = dst_reg_r;
	assign wr_size_o   = wr_size_r;
	assign wr_data_o   = wr_data_r;
	assign ccr_upd_o   = ccr_upd_r;
	assign ccr_n_o     = ccr_n_r;
	assign ccr_z_o     = ccr_z_r;

endmodule

// ==== mvd_fetch_model.sv ====
`timescale 1ns/10ps
// Stand-in for the fetch stage: one word per request, then the lines carry the inverse of the last value.
// Driving the inverse stops a stale word from passing for a fresh one.
module mvd_fetch_model (
	input  wire logic   clk_i,
	output logic        valid_o,
	output logic [15:0] instr_o,
	output logic [31:0] data_o
);
	initial begin
		valid_o = 1'h0;
		instr_o = 16'h0000;
		data_o  = 32'h00000000;
	end

	task automatic issue(input logic [15:0] ins, input logic [31:0] src);
		@(negedge clk_i);
		valid_o = 1'h1;
		instr_o = ins;
		data_o  = src;
		@(negedge clk_i);
		valid_o = 1'h0;
		instr_o = ~ins;
		data_o  = ~src;
	endtask
endmodule

// ==== mvd_top_sva.sv ====
`timescale 1ns/10ps
module mvd_top_chk (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [31:0] src_data_i,
	input wire logic        done_o,
	input wire logic        illegal_o,
	input wire logic        unhandled_o,
	input wire logic        wr_dreg_o,
	input wire logic        wr_areg_o,
	input wire logic        wr_mem_o,
	input wire logic [2:0]  dst_mode_o,
	input wire logic [2:0]  dst_reg_o,
	input wire logic [1:0]  wr_size_o,
	input wire logic [31:0] wr_data_o,
	input wire logic        ccr_upd_o,
	input wire logic        ccr_n_o,
	input wire logic        ccr_z_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	AST_ONE_ANSWER: assert property (valid_i |=> $onehot({done_o, illegal_o, unhandled_o}))
		else $error("not exactly one answer");
	AST_NO_REQ: assert property (!valid_i |=> !(done_o || illegal_o || unhandled_o))
		else $error("answer without request");
	AST_ILL_NOWR: assert property (illegal_o |-> !(wr_dreg_o || wr_areg_o || wr_mem_o || ccr_upd_o))
		else $error("write on illegal word");
	AST_AREG_CC: assert property (valid_i && instr_i[15:14] == 2'h0 && instr_i[8:6] == 3'h1 |=> !ccr_upd_o)
		else $error("address move touched flags");
	AST_AREG_BYTE: assert property (valid_i && instr_i[15:12] == 4'h1 && instr_i[8:6] == 3'h1 |=> illegal_o)
		else $error("byte address move accepted");
	AST_IMM_D16: assert property (valid_i && instr_i[15:12] == 4'h2 && instr_i[8:0] == 9'h17c |=> illegal_o)
		else $error("long immediate to displacement accepted");
	AST_EXT_FAR: assert property (valid_i && instr_i[15:14] == 2'h0 && instr_i[13:12] != 2'h0
		&& instr_i[5:3] >= 3'h5 && instr_i[8:6] >= 3'h6 |=> illegal_o) else $error("far destination accepted");
	AST_QUICK_M1: assert property (valid_i && instr_i[15:9] == 7'h50 && instr_i[8:6] == 3'h5
		|=> !done_o || wr_data_o == 32'hffffffff) else $error("quick zero code not minus one");
	AST_QUICK_LONG: assert property (valid_i && instr_i[15:12] == 4'ha && instr_i[8:6] == 3'h5
		|=> !done_o || wr_size_o == 2'h2) else $error("quick move not long");
	AST_SX_DREG: assert property (valid_i && instr_i[15:12] == 4'h7 && instr_i[8:7] == 2'h2
		|=> !done_o || (wr_dreg_o && dst_reg_o == $past(instr_i[11:9]))) else $error("sign move target wrong");
	AST_SX_BYTE: assert property (valid_i && instr_i[15:12] == 4'h7 && instr_i[8:6] == 3'h4
		|=> !done_o || wr_data_o == {{24{$past(src_data_i[7])}}, $past(src_data_i[7:0])})
		else $error("byte sign extension wrong");

	COV_QUICK: cover property (valid_i && instr_i[15:12] == 4'ha ##1 done_o);
	COV_ILL: cover property (valid_i ##1 illegal_o);
	COV_SX: cover property (valid_i && instr_i[15:12] == 4'h7 ##1 done_o);
endmodule

bind mvd_top mvd_top_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(valid_i), .instr_i(instr_i),
	.src_data_i(src_data_i), .done_o(done_o), .illegal_o(illegal_o), .unhandled_o(unhandled_o),
	.wr_dreg_o(wr_dreg_o), .wr_areg_o(wr_areg_o), .wr_mem_o(wr_mem_o), .dst_mode_o(dst_mode_o),
	.dst_reg_o(dst_reg_o), .wr_size_o(wr_size_o), .wr_data_o(wr_data_o), .ccr_upd_o(ccr_upd_o),
	.ccr_n_o(ccr_n_o), .ccr_z_o(ccr_z_o));

// ==== tb_move_instruction_decode.sv ====
`timescale 1ns/10ps
module tb_move_instruction_decode;
	logic        clk_i;
	logic        nrst_i;
	logic        valid_i;
	logic [15:0] instr_i;
	logic [31:0] src_data_i;
	logic        done_o, illegal_o, unhandled_o, wr_dreg_o, wr_areg_o, wr_mem_o;
	logic [2:0]  dst_mode_o, dst_reg_o;
	logic [1:0]  wr_size_o;
	logic [31:0] wr_data_o;
	logic        ccr_upd_o, ccr_n_o, ccr_z_o;
	int          n_fail;
	int          compares;

	mvd_fetch_model fetch (.clk_i(clk_i), .valid_o(valid_i), .instr_o(instr_i), .data_o(src_data_i));

	mvd_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(valid_i), .instr_i(instr_i), .src_data_i(src_data_i),
		.done_o(done_o), .illegal_o(illegal_o), .unhandled_o(unhandled_o), .wr_dreg_o(wr_dreg_o),
		.wr_areg_o(wr_areg_o), .wr_mem_o(wr_mem_o), .dst_mode_o(dst_mode_o), .dst_reg_o(dst_reg_o),
		.wr_size_o(wr_size_o), .wr_data_o(wr_data_o), .ccr_upd_o(ccr_upd_o), .ccr_n_o(ccr_n_o),
		.ccr_z_o(ccr_z_o));

	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Answer code: 4 executed, 2 illegal, 1 not a move; the pulses are read while they stand.
	task automatic run(input logic [15:0] ins, input logic [31:0] src, input logic [2:0] ans);
		fetch.issue(ins, src);
		chk("answer", {29'h0, done_o, illegal_o, unhandled_o}, {29'h0, ans});
	endtask

	task automatic t_move();
		run(16'h2001, 32'h80000000, 3'h4);
		chk("long", {26'h0, wr_size_o, wr_dreg_o, ccr_upd_o, ccr_n_o, ccr_z_o}, 32'h2e);
		run(16'h1481, 32'h000001ff, 3'h4);
		chk("byte", {23'h0, wr_size_o, wr_mem_o, dst_mode_o, dst_reg_o}, 32'hd2);
		chk("bdata", wr_data_o, 32'h000000ff);
		run(16'h3001, 32'h12340000, 3'h4);
		chk("word", {29'h0, wr_size_o, ccr_z_o}, 32'h7);
		run(16'h23c1, 32'h1, 3'h4);
		run(16'h21e1, 32'h1, 3'h4);
		run(16'h33e9, 32'h1, 3'h2);
		run(16'h31bc, 32'h1, 3'h2);
		run(16'h117c, 32'h1, 3'h4);
		run(16'h317c, 32'h1, 3'h4);
		run(16'h217c, 32'h1, 3'h2);
		run(16'h29c1, 32'h1, 3'h2);
		run(16'h4e71, 32'h1, 3'h1);
	endtask

	task automatic t_areg();
		run(16'h2001, 32'h0, 3'h4);
		run(16'h3041, 32'h00008000, 3'h4);
		chk("aflags", {26'h0, wr_areg_o, wr_dreg_o, ccr_upd_o, ccr_n_o, ccr_z_o, 1'h0}, 32'h22);
		chk("amode", {29'h0, dst_mode_o}, 32'h1);
		chk("adata", wr_data_o, 32'hffff8000);
		run(16'h227c, 32'h12345678, 3'h4);
		chk("adata", wr_data_o, 32'h12345678);
		chk("areg", {28'h0, wr_areg_o, dst_reg_o}, 32'h9);
		run(16'h307a, 32'h1, 3'h4);
		run(16'h1041, 32'h1, 3'h2);
	endtask

	task automatic t_quick();
		for (int c = 0; c < 8; c++) begin
			run(16'ha142 | 16'(c << 9), 32'h5a5a5a5a, 3'h4);
			chk("qdata", wr_data_o, (c == 0) ? 32'hffffffff : 32'(c));
			chk("qsize", {26'h0, wr_size_o, wr_dreg_o, dst_reg_o}, 32'h2a);
		end
		run(16'ha17a, 32'h1, 3'h2);
		run(16'ha17c, 32'h1, 3'h2);
		run(16'ha179, 32'h1, 3'h4);
		chk("qmem", {25'h0, wr_mem_o, dst_mode_o, dst_reg_o}, 32'h79);
		run(16'ha042, 32'h1, 3'h1);
	endtask

	task automatic t_sext();
		run(16'h7701, 32'h00000080, 3'h4);
		chk("sx", wr_data_o, 32'hffffff80);
		chk("sxreg", {28'h0, wr_dreg_o, dst_reg_o}, 32'hb);
		run(16'h7701, 32'h1234567f, 3'h4);
		chk("sx", wr_data_o, 32'h0000007f);
		run(16'h7741, 32'h00018000, 3'h4);
		chk("sx", wr_data_o, 32'hffff8000);
		run(16'h7741, 32'hffff7fff, 3'h4);
		chk("sx", wr_data_o, 32'h00007fff);
	endtask

	// Reset in mid-run clears held results; the first word after release is decoded at once.
	task automatic t_reset();
		run(16'h2001, 32'h1, 3'h4);
		nrst_i = 1'h0;
		@(negedge clk_i);
		chk("rst", {wr_size_o, wr_dreg_o, ccr_upd_o, done_o, wr_data_o[26:0]}, 32'h0);
		nrst_i = 1'h1;
		run(16'h7701, 32'h00000080, 3'h4);
		chk("sx", wr_data_o, 32'hffffff80);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The whole run needs well under a thousand cycles, so ten thousand means a hang.
	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end

	initial begin
		n_fail = 0;
		compares = 0;
		nrst_i = 1'h0;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		nrst_i = 1'h1;
		t_move();
		t_areg();
		t_quick();
		t_sext();
		t_reset();
		end_of_test();
	end
endmodule
